/* pkg/daic_regs.svh */
// Purpose: register offsets, field positions and reset values of the conditioning block
// Assumes: byte offsets as seen on the register port
// Notes:   definitions only
`ifndef DAIC_REGS_SVH
`define DAIC_REGS_SVH

// register offsets
`define DAIC_OFS_CH1_VAL   5'h00
`define DAIC_OFS_CH2_VAL   5'h02
`define DAIC_OFS_FILT      5'h10
`define DAIC_OFS_TYPE      5'h12
`define DAIC_OFS_LOLIM     5'h14
`define DAIC_OFS_UPLIM     5'h16
`define DAIC_OFS_STAT      5'h1e

// field positions
`define DAIC_FILT_LVL_LSB  0
`define DAIC_FILT_RAMP_LSB 4
`define DAIC_TYPE_CUR_LSB  0
`define DAIC_TYPE_RNG_LSB  4

// writable bits, the rest are reserved
`define DAIC_FILT_MASK     8'h77
`define DAIC_TYPE_MASK     8'h33

// reset values
`define DAIC_FILT_RST      8'h00
`define DAIC_TYPE_RST      8'h00
`define DAIC_LOLIM_RST     16'h8000
`define DAIC_UPLIM_RST     16'h7fff

// fixed output values
`define DAIC_VAL_MAX       16'h7fff
`define DAIC_VAL_VMIN      16'h8001
`define DAIC_VAL_INVALID   16'h8000
`define DAIC_VAL_ZERO      16'h0000

`endif

/* pkg/daic_pkg.sv */
// Purpose: shared types of the conditioning block
// Assumes: nothing
// Notes:   status codes as they appear in the status register
package daic_pkg;
   typedef enum logic [1:0] {
      DAIC_ST_OK   = 2'h0,
      DAIC_ST_LOW  = 2'h1,
      DAIC_ST_HIGH = 2'h2,
      DAIC_ST_OPEN = 2'h3
   } daic_stat_t;
endpackage

/* hw/daic_filter.sv */
// Purpose: ramp limiter and recursive low-pass filter for one channel
// Assumes: one sample per in_valid pulse
// Notes:   result stands one cycle after the sample
`timescale 1ns/1ps
`include "daic_regs.svh"
module daic_filter
   import daic_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   input  wire logic [2:0]   lvl,
   input  wire logic [2:0]   ramp,
   output logic              out_valid,
   output logic [W-1:0]      out_data
);
   logic signed [W-1:0] y_reg;
   logic signed [W-1:0] y_next;
   logic signed [W-1:0] trk;
   logic signed [W:0]   diff;
   logic signed [W:0]   lim;
   logic signed [W+1:0] ye;
   logic signed [W+1:0] te;
   logic signed [W+1:0] acc;

   // smallest step limit is the largest positive word shifted right by 7, zero below 9 bits
   if (W < 9) begin : g_chk
      $error("daic_filter: W must be at least 9");
   end

   // step limits are the largest positive word halved per code step
   assign lim  = $signed({2'b00, {(W-1){1'b1}}} >> ramp);
   assign diff = $signed({in_data[W-1], in_data}) - $signed({y_reg[W-1], y_reg});

   // ramp limit first, only while the filter runs
   always_comb begin
      trk = $signed(in_data);
      if (ramp != 3'h0) begin
         if (diff > lim) begin
            trk = y_reg + lim[W-1:0];
         end else if (diff < -lim) begin
            trk = y_reg - lim[W-1:0];
         end
      end
      ye     = {{2{y_reg[W-1]}}, y_reg};
      te     = {{2{trk[W-1]}}, trk};
      acc    = ye - (ye >>> lvl) + (te >>> lvl);
      y_next = (lvl == 3'h0) ? $signed(in_data) : acc[W-1:0];
   end

   // filter state, cleared so the first result starts from zero
   always_ff @(posedge clk) begin
      if (srst) begin
         y_reg     <= '0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            y_reg <= y_next;
         end
      end
   end

   assign out_data = y_reg;
endmodule

/* hw/daic_limit.sv */
// Purpose: limit monitoring and clamping of one channel value
// Assumes: limits shared by all channels arrive from the register file
// Notes:   value and status registered, one cycle after in_valid
`timescale 1ns/1ps
`include "daic_regs.svh"
module daic_limit
   import daic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        in_valid,
   input  wire logic [15:0] in_data,
   input  wire logic        invalid,
   input  wire logic        open_line,
   input  wire logic        is_current,
   input  wire logic        rng_4_20,
   input  wire logic        lo_written,
   input  wire logic [15:0] lo_lim,
   input  wire logic [15:0] up_lim,
   output logic             out_valid,
   output logic [15:0]      out_data,
   output daic_stat_t       out_stat
);
   logic signed [15:0] lo_eff;
   logic               lo_flag;
   logic [15:0]        d_next;
   daic_stat_t         s_next;

   // mode defaults until software writes its own lower limit
   assign lo_eff  = lo_written ? $signed(lo_lim)
                  : (is_current ? $signed(`DAIC_VAL_ZERO) : $signed(`DAIC_VAL_VMIN));
   // default 0..20 mA floors silently, 4..20 mA flags
   assign lo_flag = lo_written | ~is_current | rng_4_20;

   // priority: invalid sample, open line, overshoot, undershoot
   always_comb begin
      d_next = in_data;
      s_next = DAIC_ST_OK;
      if (invalid) begin
         d_next = `DAIC_VAL_INVALID;
      end else if (open_line && !is_current) begin
         d_next = `DAIC_VAL_MAX;
         s_next = DAIC_ST_OPEN;
      end else if ($signed(in_data) > $signed(up_lim)) begin
         d_next = up_lim;
         s_next = DAIC_ST_HIGH;
      end else if ($signed(in_data) < lo_eff) begin
         d_next = lo_eff;
         s_next = lo_flag ? DAIC_ST_LOW : DAIC_ST_OK;
      end
   end

   // result registers
   always_ff @(posedge clk) begin
      if (srst) begin
         out_valid <= 1'b0;
         out_data  <= `DAIC_VAL_ZERO;
         out_stat  <= DAIC_ST_OK;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_data <= d_next;
            out_stat <= s_next;
         end
      end
   end
endmodule

/* hw/daic_top.sv */
// Purpose: two-channel analog input conditioning with its register file
// Assumes: converter samples arrive on clk; open-line flags come from pins
// Notes:   registers reached at their byte offsets through a simple port
`timescale 1ns/1ps
`include "daic_regs.svh"

// How it works
// - filter level code 0 off, codes 1..7 divide by 2..128.
// - ramp code 0 unlimited, codes 1..7 limit steps 16383 down to 255.
// - filter configuration resets to zero: no filter, no ramp limit.
// - type bit 0/1 picks voltage or current for channel one/two.
// - range bits 4/5 pick 0..20 mA when clear, 4..20 mA when set.
// - input path selector follows the channel type automatically.
// - default upper limit +32767 always, default lower -32767 for voltage.
// - default 4..20 mA clamps below 4 mA to 0 and flags low.
// - one limit pair for all channels, active as soon as written.
// - below lower limit outputs the lower limit and flags low, except default 0..20 mA.
// - above upper limit outputs the upper limit and flags high.
// - lower limit is signed 16 bit, reset -32768.
// - upper limit is signed 16 bit, reset 32767.
// - any status change sends a message to the master unasked.
// - status holds two-bit codes per channel: ok, low, high, open.
// - default 0..20 mA floors at zero without a low flag.
// - filtered value moves by (input minus old) over the divisor.
// - ramp limit runs before the filter and only with it.
// - errors output 0x7fff, 0x8001 or 0x8000 unless limits changed.
// - open line is reported only on voltage channels.
module daic_top
   import daic_pkg::*;
#(
   parameter int CHANNELS = 2
) (
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic [4:0]                reg_addr,
   input  wire logic                      reg_wr_en,
   input  wire logic [15:0]               reg_wdata,
   input  wire logic                      reg_rd_en,
   output logic [15:0]                    reg_rdata,
   output logic                           reg_rd_valid,
   input  wire logic [CHANNELS-1:0]       adc_valid,
   input  wire logic [CHANNELS-1:0][15:0] adc_data,
   input  wire logic [CHANNELS-1:0]       adc_invalid,
   input  wire logic [CHANNELS-1:0]       open_line_pin,
   output logic [CHANNELS-1:0]            path_sel_current,
   output logic                           stat_msg_valid,
   output logic [7:0]                     stat_msg_data
);
   // the status register has room for two channels only
   if (CHANNELS != 2) begin : g_chk
      $error("daic_top: CHANNELS must be 2");
   end

   logic [7:0]                filt_reg;
   logic [7:0]                type_reg;
   logic [15:0]               lolim_reg;
   logic [15:0]               uplim_reg;
   logic                      lo_written_reg;
   logic [3:0]                stat_reg;
   logic [3:0]                stat_next;
   logic [15:0]               val_reg [CHANNELS];
   logic [CHANNELS-1:0]       open_meta_reg;
   logic [CHANNELS-1:0]       open_sync_reg;
   logic [CHANNELS-1:0]       flt_valid;
   logic [CHANNELS-1:0][15:0] flt_data;
   logic [CHANNELS-1:0]       lim_valid;
   logic [CHANNELS-1:0][15:0] lim_data;
   daic_stat_t                lim_stat [CHANNELS];
   logic [15:0]               rd_next;

   // write strobes per register
   wire wr_filt  = reg_wr_en && (reg_addr == `DAIC_OFS_FILT);
   wire wr_type  = reg_wr_en && (reg_addr == `DAIC_OFS_TYPE);
   wire wr_lolim = reg_wr_en && (reg_addr == `DAIC_OFS_LOLIM);
   wire wr_uplim = reg_wr_en && (reg_addr == `DAIC_OFS_UPLIM);

   // configuration fields
   wire [2:0] filt_lvl  = filt_reg[`DAIC_FILT_LVL_LSB +: 3];
   wire [2:0] filt_ramp = filt_reg[`DAIC_FILT_RAMP_LSB +: 3];
   wire [1:0] type_cur  = type_reg[`DAIC_TYPE_CUR_LSB +: 2];
   wire [1:0] type_rng  = type_reg[`DAIC_TYPE_RNG_LSB +: 2];

   // configuration registers; reserved bits dropped at write time
   always_ff @(posedge clk) begin
      if (srst) begin
         filt_reg       <= `DAIC_FILT_RST;
         type_reg       <= `DAIC_TYPE_RST;
         lolim_reg      <= `DAIC_LOLIM_RST;
         uplim_reg      <= `DAIC_UPLIM_RST;
         lo_written_reg <= 1'b0;
      end else begin
         if (wr_filt) begin
            filt_reg <= reg_wdata[7:0] & `DAIC_FILT_MASK;
         end
         if (wr_type) begin
            type_reg <= reg_wdata[7:0] & `DAIC_TYPE_MASK;
         end
         if (wr_lolim) begin
            lolim_reg      <= reg_wdata;
            lo_written_reg <= 1'b1;
         end
         if (wr_uplim) begin
            uplim_reg <= reg_wdata;
         end
      end
   end

   // input switch follows the type, registered to keep the pin glitch-free
   always_ff @(posedge clk) begin
      if (srst) begin
         path_sel_current <= '0;
      end else begin
         path_sel_current <= type_cur;
      end
   end

   // open-line flags come from the analog side, two stages before use
   always_ff @(posedge clk) begin
      if (srst) begin
         open_meta_reg <= '0;
         open_sync_reg <= '0;
      end else begin
         open_meta_reg <= open_line_pin;
         open_sync_reg <= open_meta_reg;
      end
   end

   // per-channel processing: filter, then limits shared by all channels
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
      daic_filter #(
         .W (16)
      ) u_filter (
         .clk       (clk),
         .srst      (srst),
         .in_valid  (adc_valid[ch]),
         .in_data   (adc_data[ch]),
         .lvl       (filt_lvl),
         .ramp      (filt_ramp),
         .out_valid (flt_valid[ch]),
         .out_data  (flt_data[ch])
      );

      // invalid flag is delayed to line up with the filter result
      logic inv_reg;
      always_ff @(posedge clk) begin
         if (srst) begin
            inv_reg <= 1'b0;
         end else if (adc_valid[ch]) begin
            inv_reg <= adc_invalid[ch];
         end
      end

      daic_limit u_limit (
         .clk        (clk),
         .srst       (srst),
         .in_valid   (flt_valid[ch]),
         .in_data    (flt_data[ch]),
         .invalid    (inv_reg),
         .open_line  (open_sync_reg[ch]),
         .is_current (type_cur[ch]),
         .rng_4_20   (type_rng[ch]),
         .lo_written (lo_written_reg),
         .lo_lim     (lolim_reg),
         .up_lim     (uplim_reg),
         .out_valid  (lim_valid[ch]),
         .out_data   (lim_data[ch]),
         .out_stat   (lim_stat[ch])
      );

      // status field of this channel, updated with each new result
      assign stat_next[2*ch +: 2] = lim_valid[ch] ? lim_stat[ch] : stat_reg[2*ch +: 2];
   end

   // channel values and status, updated as results arrive
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            val_reg[i] <= `DAIC_VAL_ZERO;
         end
         stat_reg       <= '0;
         stat_msg_valid <= 1'b0;
         stat_msg_data  <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (lim_valid[i]) begin
               val_reg[i] <= lim_data[i];
            end
         end
         stat_reg       <= stat_next;
         stat_msg_valid <= (stat_next != stat_reg);
         if (stat_next != stat_reg) begin
            stat_msg_data <= {4'h0, stat_next};
         end
      end
   end

   // read decode; write-only and unmapped offsets read as zero
   wire rd_ch1  = (reg_addr == `DAIC_OFS_CH1_VAL);
   wire rd_ch2  = (reg_addr == `DAIC_OFS_CH2_VAL);
   wire rd_stat = (reg_addr == `DAIC_OFS_STAT);
   assign rd_next = rd_ch1  ? val_reg[0]
                  : rd_ch2  ? val_reg[1]
                  : rd_stat ? {12'h000, stat_reg}
                  : 16'h0000;

   // read data stands one cycle after the request
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata    <= '0;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata <= rd_next;
         end
      end
   end

   // checks on the behaviour of the register file and results
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence lo_write_s;
      wr_lolim ##1 lo_written_reg;
   endsequence

   // reset state of the configuration
   cfg_reset_val_a: assert property ($past(srst) |->
      filt_reg == 8'h00 && lolim_reg == 16'h8000 && uplim_reg == 16'h7fff)
      else $error("configuration not at reset values");

   // reserved filter bits never stored
   filt_write_mask_a: assert property (wr_filt |=>
      filt_reg == ($past(reg_wdata[7:0]) & 8'h77))
      else $error("filter configuration write wrong");

   // switch follows type two edges after a write
   path_sel_follow_a: assert property (wr_type |=> ##1
      path_sel_current == $past(type_reg[1:0]))
      else $error("input path selector does not follow type");

   // lower limit write arms monitoring and holds the value
   lo_limit_arm_a: assert property (lo_write_s |->
      lolim_reg == $past(reg_wdata))
      else $error("lower limit not armed by write");

   // status change always announced once
   stat_msg_send_a: assert property (stat_msg_valid == $changed(stat_reg))
      else $error("status change not matched by message");

   // message carries the new status
   stat_msg_data_a: assert property (stat_msg_valid |->
      stat_msg_data == {4'h0, stat_reg})
      else $error("status message carries wrong code");

   // open line only on voltage channels
   open_volt_only_a: assert property (lim_valid[0] && lim_stat[0] == DAIC_ST_OPEN |->
      $past(type_cur[0]) == 1'b0)
      else $error("open line reported on a current channel");

   // clamped high results equal the upper limit
   up_clamp_val_a: assert property (lim_valid[0] && lim_stat[0] == DAIC_ST_HIGH |->
      lim_data[0] == $past(uplim_reg))
      else $error("overshoot not clamped to upper limit");

   // written lower limit clamps undershoot
   lo_clamp_val_a: assert property (lim_valid[1] && lim_stat[1] == DAIC_ST_LOW
      && $past(lo_written_reg) |-> lim_data[1] == $past(lolim_reg))
      else $error("undershoot not clamped to lower limit");

   // default 0..20 mA never goes negative and never flags low
   cur_floor_zero_a: assert property (lim_valid[0] && $past(type_cur[0])
      && !$past(type_rng[0]) && !$past(lo_written_reg) && !$past(g_ch[0].inv_reg)
      |-> !lim_data[0][15] && lim_stat[0] != DAIC_ST_LOW)
      else $error("default current range floor broken");

   // status read keeps reserved bits at zero
   stat_read_resv_a: assert property (reg_rd_en && rd_stat |=>
      reg_rd_valid && reg_rdata[15:4] == 12'h000)
      else $error("reserved status bits read non-zero");
endmodule

/* test/daic_master.sv */
// Purpose: register-port master standing in for the bus controller
// Assumes: one strobe per request, answer registered at the sampling edge
// Notes:   address and data are inverted when idle so stale values never match
`timescale 1ns/1ps
module daic_master (
   input  wire logic        clk,
   output logic [4:0]       reg_addr,
   output logic             reg_wr_en,
   output logic [15:0]      reg_wdata,
   output logic             reg_rd_en,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rd_valid
);
   // idle state at time zero
   initial begin
      reg_addr = 5'h1f;
      reg_wr_en = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd_en = 1'b0;
   end

   // write: strobe stands for exactly one sampling edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // read: bounded wait for the answer, unknown returned if it never comes
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      int i;
      @(posedge clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      for (i = 0; i < 4 && reg_rd_valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      d = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hxxxx;
   endtask
endmodule

/* test/tb_top.sv */
// Purpose: self-checking bench of the two-channel conditioning block
// Assumes: register traffic goes through daic_master
// Notes:   expectations rebuilt from shadow copies of the written registers
`timescale 1ns/1ps
`include "daic_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top
   import daic_pkg::*;
;
   logic                 clk = 1'b0;
   logic                 srst = 1'b1;
   logic [4:0]           reg_addr;
   logic                 reg_wr_en;
   logic [15:0]          reg_wdata;
   logic                 reg_rd_en;
   logic [15:0]          reg_rdata;
   logic                 reg_rd_valid;
   logic [1:0]           adc_valid;
   logic [1:0][15:0]     adc_data;
   logic [1:0]           adc_invalid;
   logic [1:0]           open_line_pin;
   logic [1:0]           path_sel_current;
   logic                 stat_msg_valid;
   logic [7:0]           stat_msg_data;
   logic [7:0]           typ_r;
   logic [15:0]          lo_r;
   logic [15:0]          up_r;
   logic                 lo_w;
   logic [7:0]           prev;
   logic [1:0]           st[2];
   int                   lvl;
   int                   rmp;
   int                   y[2];
   int                   n_errors = 0;
   int                   n_checks = 0;
   logic [4:0]           ofs[8] = '{5'h00, 5'h02, 5'h10, 5'h12, 5'h14, 5'h16, 5'h1e, 5'h08};

   // 50 MHz clock
   always #10 clk = ~clk;

   daic_top daic_top_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .adc_valid(adc_valid), .adc_data(adc_data),
      .adc_invalid(adc_invalid), .open_line_pin(open_line_pin),
      .path_sel_current(path_sel_current), .stat_msg_valid(stat_msg_valid),
      .stat_msg_data(stat_msg_data));

   daic_master daic_master_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // reset plus shadow defaults; filter state restarts at zero
   task automatic rst(input int n);
      @(posedge clk);
      srst <= 1'b1;
      cyc(n);
      srst <= 1'b0;
      typ_r = 8'h00;
      lo_r = 16'h8000;
      up_r = 16'h7fff;
      lo_w = 1'b0;
      lvl = 0;
      rmp = 0;
      y = '{0, 0};
      st = '{2'h0, 2'h0};
      prev = 8'h00;
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [15:0] e, input string nm);
      logic [15:0] v;
      daic_master_inst.rd(a, v);
      `CHK(nm, e, v)
   endtask

   // write through the master and mirror the effect; reserved bits dropped
   task automatic setreg(input logic [4:0] a, input logic [15:0] d);
      daic_master_inst.wr(a, d);
      if (a == `DAIC_OFS_FILT) begin
         lvl = d[2:0];
         rmp = d[6:4];
      end
      if (a == `DAIC_OFS_TYPE) typ_r = d[7:0] & 8'h33;
      if (a == `DAIC_OFS_UPLIM) up_r = d;
      if (a == `DAIC_OFS_LOLIM) begin
         lo_r = d;
         lo_w = 1'b1;
      end
   endtask

   // limit stage: returns {status, value}
   function automatic logic [17:0] lim_fn(input logic [15:0] x, input logic cur,
                                          input logic r420, input logic inv, input logic opn);
      int v;
      int lo;
      v = int'($signed(x));
      lo = lo_w ? int'($signed(lo_r)) : (cur ? 0 : -32767);
      if (inv) return {2'h0, 16'h8000};
      if (opn && !cur) return {2'h3, 16'h7fff};
      if (v > int'($signed(up_r))) return {2'h2, up_r};
      if (v < lo) return {1'b0, lo_w || !cur || r420, 16'(lo)};
      return {2'h0, x};
   endfunction

   // one sample through ramp, filter and limits, then message, value and status
   task automatic smp(input int ch, input logic [15:0] x, input logic inv);
      int d;
      int t;
      int lim;
      int v;
      logic [17:0] r;
      v = int'($signed(x));
      if (lvl != 0) begin
         t = v;
         d = v - y[ch];
         lim = 32'h7fff >> rmp;
         if (rmp != 0 && d > lim) t = y[ch] + lim;
         if (rmp != 0 && d < -lim) t = y[ch] - lim;
         y[ch] = y[ch] - (y[ch] >>> lvl) + (t >>> lvl);
         v = y[ch];
      end else begin
         y[ch] = v;
      end
      r = lim_fn(16'(v), typ_r[ch], typ_r[ch] & typ_r[ch+4], inv, open_line_pin[ch]);
      @(posedge clk);
      adc_valid[ch] <= 1'b1;
      adc_data[ch] <= x;
      adc_invalid[ch] <= inv;
      @(posedge clk);
      adc_valid[ch] <= 1'b0;
      adc_data[ch] <= ~x;
      adc_invalid[ch] <= ~inv;
      cyc(2);
      #1;
      st[ch] = r[17:16];
      `CHK("msg pulse", ({4'h0, st[1], st[0]} != prev), stat_msg_valid)
      if ({4'h0, st[1], st[0]} != prev) `CHK("msg byte", {4'h0, st[1], st[0]}, stat_msg_data)
      prev = {4'h0, st[1], st[0]};
      rdchk(5'(ch * 2), r[15:0], "value");
      rdchk(`DAIC_OFS_STAT, {8'h00, prev}, "status");
   endtask

   task automatic results();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // watchdog: tests need some 1850 cycles
   initial begin
      cyc(40000);
      n_errors++;
      results();
   end

   initial begin
      adc_valid = 2'b00;
      adc_data = '0;
      adc_invalid = 2'b00;
      open_line_pin = 2'b00;
      void'($urandom(32'h970c));
      rst(16);
      foreach (ofs[i]) rdchk(ofs[i], 16'h0000, "reset read");
      $display("test reset done");
      // voltage mode with default limits, corners then random
      smp(0, 16'h8000, 1'b0);
      smp(1, 16'h7fff, 1'b0);
      repeat (20) smp($urandom % 2, 16'($urandom), 1'b0);
      smp(0, 16'h1234, 1'b1);
      daic_master_inst.wr(`DAIC_OFS_STAT, 16'hffff);
      rdchk(`DAIC_OFS_STAT, {8'h00, prev}, "ro status");
      $display("test voltage done");
      // open line only counts on voltage channels
      open_line_pin <= 2'b01;
      cyc(4);
      smp(0, 16'h0100, 1'b0);
      smp(1, 16'h0100, 1'b0);
      setreg(`DAIC_OFS_TYPE, 16'h00ff);
      cyc(1);
      #1;
      `CHK("path sel", 2'b11, path_sel_current)
      smp(0, 16'hf000, 1'b0);
      setreg(`DAIC_OFS_TYPE, 16'h0003);
      smp(0, 16'hf000, 1'b0);
      smp(1, 16'h4000, 1'b0);
      open_line_pin <= 2'b00;
      setreg(`DAIC_OFS_TYPE, 16'h0012);
      cyc(1);
      #1;
      `CHK("path sel", 2'b10, path_sel_current)
      $display("test type done");
      // limits written by the master take effect on both channels
      setreg(`DAIC_OFS_UPLIM, 16'h1000);
      smp(1, 16'h2000, 1'b0);
      setreg(`DAIC_OFS_LOLIM, 16'he000);
      smp(1, 16'hd000, 1'b0);
      smp(0, 16'hd000, 1'b0);
      repeat (10) smp($urandom % 2, 16'($urandom), 1'b0);
      $display("test limits done");
      // mid-run reset, then every ramp code with every nonzero filter level
      rst(2);
      for (int i = 0; i < 56; i++) begin
         setreg(`DAIC_OFS_FILT, 16'(((i / 7) << 4) | (i % 7 + 1) | ((i % 2) ? 8'h88 : 8'h00)));
         repeat (3) smp($urandom % 2, 16'($urandom), 1'b0);
      end
      setreg(`DAIC_OFS_FILT, 16'h0000);
      smp(0, 16'h5555, 1'b0);
      $display("test filter done");
      results();
   end
endmodule
